//--- hw/hub_strap_pkg.sv
// Constants, field layout and types shared by the strap capture block.
// Assumes a single core clock domain; no bus, all control bits are ports.
package hub_strap_pkg;

    // Number of downstream ports served by the LED and strap pins
    localparam int PORT_COUNT = 2;

    // Layout of the captured strap word
    localparam int STRAP_W = 5;
    localparam int POS_POLARITY = 0;
    localparam int POS_FIXED_LO = 1;
    localparam int POS_FIXED_HI = 2;
    localparam int POS_SEL0 = 3;
    localparam int POS_SEL1 = 4;

    // Reset value of the strap latch before any capture
    localparam logic [STRAP_W-1:0] STRAP_RESET = 5'h00;

    // Captured polarity of one means an active-high power enable
    localparam logic POLARITY_HIGH = 1'b1;

    // Seven-bit slave address used when the host downloads descriptors
    localparam logic [6:0] SLAVE_ADDRESS = 7'h2C;

    // Fixed-port strap pair codes
    localparam logic [1:0] FIXED_NONE = 2'h0;
    localparam logic [1:0] FIXED_PORT1 = 2'h1;
    localparam logic [1:0] FIXED_PORTS12 = 2'h2;
    localparam logic [1:0] FIXED_BOTH_LOW = 2'h3;

    // Configuration source picked by the two select straps
    typedef enum logic [1:0] {
        CFG_SLAVE,
        CFG_DEFAULT,
        CFG_EEPROM
    } config_mode_t;

    // Select bit 1 low always means bus slave, bit 0 then ignored
    function automatic config_mode_t source_mode(input logic sel1,
                                                 input logic sel0);
        config_mode_t mode;
        mode = CFG_SLAVE;
        if (sel1 && !sel0) begin
            mode = CFG_DEFAULT;
        end else if (sel1 && sel0) begin
            mode = CFG_EEPROM;
        end
        return mode;
    endfunction

    // Which ports hold permanently attached devices for a strap pair
    function automatic logic [1:0] fixed_ports(input logic [1:0] pair);
        logic [1:0] ports;
        ports = 2'h0;
        case (pair)
            FIXED_NONE: ports = 2'h0;
            FIXED_PORT1: ports = 2'h1;
            FIXED_PORTS12: ports = 2'h3;
            FIXED_BOTH_LOW: ports = 2'h3;
            default: ports = 2'h0;
        endcase
        return ports;
    endfunction

endpackage

//--- hw/strap_latch.sv
// Strap latch: holds a word of strap pins taken at reset release.
// Assumes reset is asynchronous active high and straps are stable
// around the release; capture happens on the first clock edge after it.
`timescale 1ns/1ps
`default_nettype none
module strap_latch #(
    parameter int WIDTH = 5
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] strapIn,
    output var logic [WIDTH-1:0] strapValue,
    output var logic strapValid
);

    // A strap cannot be loaded under async reset, so the first edge
    // after release takes it; later edges leave it alone until reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            strapValue <= '0;
            strapValid <= 1'b0;
        end else if (!strapValid) begin
            strapValue <= strapIn;
            strapValid <= 1'b1;
        end
    end

endmodule
`default_nettype wire

//--- hw/hub_strap_capture_port_power.sv
// Strap capture, port power enable and port LED logic of a two-port hub.
// Assumes reset is the chip reset pin in active-high form, all inputs
// synchronous to sys_clk, and the pad ring resolving two-way pins.
//
// What this block does
// - One port power enable output, active level set by latched polarity.
// - During reset, power enable is the inactive level of the live strap.
// - Polarity strap captured at reset release, held until the next reset.
// - Captured one means active-high enable, zero means active-low enable.
// - With serial setup and LED support on, both port LEDs are active low.
// - Default setup samples the shared LED pins at release for fixed ports.
// - Pair 00: all ports removable, both LEDs active high.
// - Pair 01: port 1 fixed, LED 2 active high, LED 1 active low.
// - Pair 10: ports 1 and 2 fixed, LED 2 low, LED 1 high.
// - Pair 11: ports 1 and 2 fixed, both LEDs active low.
// - Monitor pulls overcurrent low; undriven input reads as no fault.
// - Serial clock pin read at release as setup select bit 0.
// - Select bit 1 read at release, combined with bit 0 for the method.
// - Select bit 1 low: bus slave at address 0101100, bit 0 ignored.
// - Bit 1 high: bit 0 low picks default, high picks memory load.
`timescale 1ns/1ps
`default_nettype none
module hub_strap_capture_port_power #(
    parameter int PORTS = hub_strap_pkg::PORT_COUNT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic powerPolarityStrap,
    input wire logic setupSourceBit0,
    input wire logic setupSourceBit1,
    input wire logic [PORTS-1:0] fixedPortStrapIn,
    input wire logic overcurrentInLow,
    input wire logic overcurrentDriven,
    input wire logic powerRequest,
    input wire logic ledSupportEnable,
    input wire logic [PORTS-1:0] portLedOn,
    output logic portPowerEnable,
    output var logic [PORTS-1:0] portLedOut,
    output var logic [PORTS-1:0] portLedOe,
    output var logic [PORTS-1:0] nonRemovable,
    output var hub_strap_pkg::config_mode_t configMode,
    output logic [6:0] slaveAddress,
    output var logic overcurrentFault,
    output logic strapsCaptured
);

    logic [hub_strap_pkg::STRAP_W-1:0] liveStraps;
    logic [hub_strap_pkg::STRAP_W-1:0] strapValue;
    logic strapValid;
    logic capturedPolarity;
    logic [1:0] fixedPair;
    hub_strap_pkg::config_mode_t next_mode;
    logic powerOn;
    logic [PORTS-1:0] next_activeLow;
    logic next_ledDrive;
    logic overcurrentLevel;

    // Gather the straps into one word for the latch
    assign liveStraps = {setupSourceBit1, setupSourceBit0,
                         fixedPortStrapIn[1:0], powerPolarityStrap};

    // Sample all straps together on the first edge after release
    strap_latch #(
        .WIDTH(hub_strap_pkg::STRAP_W)
    ) u_strap_latch (
        .sys_clk(sys_clk),
        .reset(reset),
        .strapIn(liveStraps),
        .strapValue(strapValue),
        .strapValid(strapValid)
    );

    assign strapsCaptured = strapValid;
    assign capturedPolarity = strapValue[hub_strap_pkg::POS_POLARITY];
    assign fixedPair = strapValue[hub_strap_pkg::POS_FIXED_HI:
                                  hub_strap_pkg::POS_FIXED_LO];

    // Method from both select bits as captured
    assign next_mode = hub_strap_pkg::source_mode(
        strapValue[hub_strap_pkg::POS_SEL1],
        strapValue[hub_strap_pkg::POS_SEL0]);

    // Address is fixed; only meaningful while in slave mode
    assign slaveAddress = hub_strap_pkg::SLAVE_ADDRESS;

    // Power request is only honoured once polarity is known
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            powerOn <= 1'b0;
        end else begin
            powerOn <= powerRequest && strapValid;
        end
    end

    // Combinational on purpose: before capture the enable must follow the
    // live strap so downstream power stays off while reset is held
    always_comb begin
        if (!strapValid) begin
            portPowerEnable = !powerPolarityStrap;
        end else if (powerOn) begin
            portPowerEnable = capturedPolarity;
        end else begin
            portPowerEnable = !capturedPolarity;
        end
    end

    // Configuration method register, settles one edge after capture
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            configMode <= hub_strap_pkg::CFG_SLAVE;
        end else if (strapValid) begin
            configMode <= next_mode;
        end
    end

    // Fixed ports only come from straps in the default setup
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nonRemovable <= '0;
        end else if (strapValid && next_mode == hub_strap_pkg::CFG_DEFAULT)
        begin
            nonRemovable <= hub_strap_pkg::fixed_ports(fixedPair);
        end else begin
            nonRemovable <= '0;
        end
    end

    // LED polarity and drive: straps decide in the default setup, the
    // serial setup drives LEDs active low only while LED support is enabled
    always_comb begin
        next_activeLow = '0;
        next_ledDrive = 1'b0;
        case (next_mode)
            hub_strap_pkg::CFG_DEFAULT: begin
                next_activeLow = fixedPair;
                next_ledDrive = strapValid;
            end
            hub_strap_pkg::CFG_SLAVE,
            hub_strap_pkg::CFG_EEPROM: begin
                next_activeLow = '1;
                next_ledDrive = strapValid && ledSupportEnable;
            end
            default: begin
                next_activeLow = '0;
                next_ledDrive = 1'b0;
            end
        endcase
    end

    // Pins stay undriven in reset so the strap resistors can be read
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            portLedOut <= '0;
            portLedOe <= '0;
        end else begin
            portLedOut <= portLedOn ^ next_activeLow;
            portLedOe <= {PORTS{next_ledDrive}};
        end
    end

    // Undriven pin floats high through the pull-up, meaning no fault
    assign overcurrentLevel = overcurrentDriven ? overcurrentInLow : 1'b1;

    // Fault flag follows the pin, low means overcurrent
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            overcurrentFault <= 1'b0;
        end else begin
            overcurrentFault <= !overcurrentLevel;
        end
    end

    // Checks on the block's own outputs
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_power_before_capture;
        !strapValid |-> portPowerEnable == !powerPolarityStrap;
    endproperty
    a_power_before_capture: assert property (p_power_before_capture)
        else $error("power enable not inactive before strap capture");

    property p_polarity_held;
        strapValid ##1 strapValid |->
            capturedPolarity == $past(capturedPolarity);
    endproperty
    a_polarity_held: assert property (p_polarity_held)
        else $error("captured polarity changed after capture");

    property p_power_active_level;
        $past(powerRequest) && strapValid && $past(strapValid) |->
            portPowerEnable == capturedPolarity;
    endproperty
    a_power_active_level: assert property (p_power_active_level)
        else $error("power enable not at captured active level");

    property p_power_off_release;
        $rose(strapValid) |-> portPowerEnable != capturedPolarity;
    endproperty
    a_power_off_release: assert property (p_power_off_release)
        else $error("power enabled without a request after release");

    property p_power_idle;
        strapValid && !powerRequest |=> portPowerEnable == !capturedPolarity;
    endproperty
    a_power_idle: assert property (p_power_idle)
        else $error("power enable active without request");

    property p_mode_decode;
        $rose(strapValid) |=>
            (configMode == hub_strap_pkg::CFG_SLAVE) ==
                !strapValue[hub_strap_pkg::POS_SEL1] &&
            (configMode == hub_strap_pkg::CFG_EEPROM) ==
                (strapValue[hub_strap_pkg::POS_SEL1] &&
                 strapValue[hub_strap_pkg::POS_SEL0]);
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("configuration method does not match select straps");

    property p_fixed_ports;
        configMode == hub_strap_pkg::CFG_DEFAULT |->
            nonRemovable == {fixedPair[1], fixedPair[1] | fixedPair[0]};
    endproperty
    a_fixed_ports: assert property (p_fixed_ports)
        else $error("non-removable ports do not match strap pair");

    property p_default_led;
        configMode == hub_strap_pkg::CFG_DEFAULT |=>
            portLedOe == '1 && portLedOut == ($past(portLedOn) ^ fixedPair);
    endproperty
    a_default_led: assert property (p_default_led)
        else $error("default setup LED polarity wrong");

    // The mode register lags capture by one edge while the LED flops
    // already follow the captured straps, so the decoded mode is watched
    property p_serial_led;
        strapValid && next_mode != hub_strap_pkg::CFG_DEFAULT &&
            ledSupportEnable |=> portLedOut == ~$past(portLedOn);
    endproperty
    a_serial_led: assert property (p_serial_led)
        else $error("serial setup LEDs not active low");

    property p_no_fault_undriven;
        !overcurrentDriven |=> !overcurrentFault;
    endproperty
    a_no_fault_undriven: assert property (p_no_fault_undriven)
        else $error("undriven overcurrent input reported as fault");

    c_default_both_low: cover property (
        configMode == hub_strap_pkg::CFG_DEFAULT && fixedPair == 2'h3);
    c_eeprom_mode: cover property (configMode == hub_strap_pkg::CFG_EEPROM);
    c_power_on: cover property (strapValid ##1 powerOn);

endmodule
`default_nettype wire

//--- tb/port_side_model.sv
// Board side of the strap block: strap resistors, LED pins, current monitor.
// Assumes the bench sets the strap levels and monitor state by command.
`timescale 1ns/1ps
`default_nettype none
module port_side_model (
    input wire logic polarityCmd,
    input wire logic [1:0] pairCmd,
    input wire logic faultCmd,
    input wire logic floatCmd,
    input wire logic [1:0] portLedOut,
    input wire logic [1:0] portLedOe,
    output logic powerPolarityStrap,
    output logic [1:0] fixedPortStrapIn,
    output logic overcurrentInLow,
    output logic overcurrentDriven
);
    // Strap resistor on the polarity pin
    assign powerPolarityStrap = polarityCmd;
    // Shared LED pin reads the resistor only while the hub lets go
    assign fixedPortStrapIn[0] = portLedOe[0] ? portLedOut[0] : pairCmd[0];
    assign fixedPortStrapIn[1] = portLedOe[1] ? portLedOut[1] : pairCmd[1];
    // Monitor pulls low on a fault; released pin rises to the pull-up
    assign overcurrentDriven = !floatCmd;
    assign overcurrentInLow = floatCmd ? 1'b1 : !faultCmd;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: every strap combination, each followed by random traffic.
// Assumes the board model above resolves the shared LED pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic bit0 = 1'b0;
    logic bit1 = 1'b0;
    logic powerRequest = 1'b0;
    logic ledSupport = 1'b0;
    logic [1:0] ledOn = 2'h0;
    logic polStrap = 1'b1;
    logic [1:0] pairStrap = 2'h0;
    logic ocFault = 1'b0;
    logic ocFloat = 1'b1;
    logic pol;
    logic [1:0] expOe;
    logic [1:0] lowMask;
    wire logic polPin, ocIn, ocDrv, power, fault, captured;
    wire logic [1:0] strapPins, ledOut, ledOe, nonRem;
    wire logic [6:0] addr;
    wire hub_strap_pkg::config_mode_t configMode;
    hub_strap_pkg::config_mode_t mode;
    int miscompares = 0;
    int checkCount = 0;
    int seed = 32'h070D;

    // 200 MHz core clock
    always #2.5 sys_clk = ~sys_clk;

    port_side_model i_board (.polarityCmd(polStrap), .pairCmd(pairStrap),
        .faultCmd(ocFault), .floatCmd(ocFloat), .portLedOut(ledOut),
        .portLedOe(ledOe), .powerPolarityStrap(polPin),
        .fixedPortStrapIn(strapPins), .overcurrentInLow(ocIn),
        .overcurrentDriven(ocDrv));

    hub_strap_capture_port_power i_dut (.sys_clk(sys_clk), .reset(reset),
        .powerPolarityStrap(polPin), .setupSourceBit0(bit0),
        .setupSourceBit1(bit1), .fixedPortStrapIn(strapPins),
        .overcurrentInLow(ocIn), .overcurrentDriven(ocDrv),
        .powerRequest(powerRequest), .ledSupportEnable(ledSupport),
        .portLedOn(ledOn), .portPowerEnable(power), .portLedOut(ledOut),
        .portLedOe(ledOe), .nonRemovable(nonRem), .configMode(configMode),
        .slaveAddress(addr), .overcurrentFault(fault),
        .strapsCaptured(captured));

    // Expected source from the two select straps
    function automatic hub_strap_pkg::config_mode_t exp_mode(input logic s1,
                                                             input logic s0);
        if (!s1) begin
            return hub_strap_pkg::CFG_SLAVE;
        end
        return s0 ? hub_strap_pkg::CFG_EEPROM : hub_strap_pkg::CFG_DEFAULT;
    endfunction

    // Fixed ports only count under the strap-driven default setup
    function automatic logic [1:0] exp_fixed(input logic [1:0] pair,
                                             input logic deflt);
        if (!deflt || pair == 2'h0) begin
            return 2'h0;
        end
        return (pair == 2'h1) ? 2'h1 : 2'h3;
    endfunction

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the 291 cycles needed
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (3) step();
        for (int i = 0; i < 32; i++) begin
            reset = 1'b1;
            {bit1, bit0, pairStrap, polStrap} = i[4:0];
            powerRequest = 1'b1;
            ledSupport = 1'($random(seed));
            ledOn = 2'($random(seed));
            ocFloat = 1'b0;
            ocFault = 1'b0;
            #1;
            chk("power in reset", {7'h0, !polStrap}, {7'h0, power});
            step();
            reset = 1'b0;
            step();
            chk("captured", 8'h01, {7'h0, captured});
            chk("power held off", {7'h0, !polStrap}, {7'h0, power});
            // Later strap moves must not alter the captured polarity
            pol = polStrap;
            polStrap = ~polStrap;
            mode = exp_mode(bit1, bit0);
            lowMask = (mode == hub_strap_pkg::CFG_DEFAULT) ? pairStrap : 2'h3;
            expOe = (mode == hub_strap_pkg::CFG_DEFAULT || ledSupport)
                    ? 2'h3 : 2'h0;
            step();
            chk("power on", {7'h0, pol}, {7'h0, power});
            chk("mode", {6'h0, mode}, {6'h0, configMode});
            chk("address", 8'h2C, {1'b0, addr});
            chk("fixed", {6'h0, exp_fixed(pairStrap,
                mode == hub_strap_pkg::CFG_DEFAULT)}, {6'h0, nonRem});
            repeat (6) begin
                powerRequest = 1'($random(seed));
                ledOn = 2'($random(seed));
                ocFloat = 1'($random(seed));
                ocFault = 1'($random(seed));
                step();
                chk("power", {7'h0, powerRequest ? pol : !pol},
                    {7'h0, power});
                chk("led oe", {6'h0, expOe}, {6'h0, ledOe});
                if (expOe != 2'h0) begin
                    chk("led out", {6'h0, ledOn ^ lowMask},
                        {6'h0, ledOut});
                end
                chk("fault", {7'h0, !ocFloat && ocFault},
                    {7'h0, fault});
                chk("fixed held", {6'h0, exp_fixed(pairStrap,
                    mode == hub_strap_pkg::CFG_DEFAULT)},
                    {6'h0, nonRem});
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
